/* src/pfc_pkg.sv */
// Constants shared by the packet and frequency configuration bank
// Behaviour
// - Format zero moves RX and TX data through the FIFOs.
// - Format one is synchronous serial, TX data taken from pin zero.
// - Format two transmits PN9 random test data instead of FIFO data.
// - Format two receives exactly as normal FIFO mode.
// - Format three is asynchronous serial, TX in on pin zero, RX out.
// - CRC bit set computes CRC in TX, checks in RX; clear disables.
// - Length mode zero uses fixed length from the packet length register.
// - Length mode one takes length from first byte after sync word.
// - Length mode two gives unbounded packets until mode changes.
// - Address filter matches device address; zero and ones may broadcast.
// - Filter mode zero to three: none, exact, plus zero, plus ones.
// - Packet length is exact fixed length or variable maximum.
// - Channel times spacing is added to the base frequency.
// - In RX the IF word times xtal over 2^10 is subtracted.
// - Signed offset step xtal over 2^14 added before synthesis.
// - Top two carrier word bits are read-only zero.
// - Carrier word is high, middle, low bytes times xtal over 2^16.
package pfc_pkg;
  // Register offsets
  localparam logic [5:0] PFC_OFS_PKTCTRL = 6'h08;
  localparam logic [5:0] PFC_OFS_ADDR = 6'h09;
  localparam logic [5:0] PFC_OFS_CHANNEL_INDEX = 6'h0a;
  localparam logic [5:0] PFC_OFS_IF = 6'h0b;
  localparam logic [5:0] PFC_OFS_OFFSET = 6'h0c;
  localparam logic [5:0] PFC_OFS_CARRIER_WORD_HI = 6'h0d;
  localparam logic [5:0] PFC_OFS_CARRIER_WORD_MID = 6'h0e;
  localparam logic [5:0] PFC_OFS_CARRIER_WORD_LO = 6'h0f;
  // Values after reset
  localparam logic [7:0] PFC_RST_PKTCTRL = 8'h45;
  localparam logic [7:0] PFC_RST_ADDR = 8'h00;
  localparam logic [7:0] PFC_RST_CHANNEL_INDEX = 8'h00;
  localparam logic [7:0] PFC_RST_IF = 8'h0f;
  localparam logic [7:0] PFC_RST_OFFSET = 8'h00;
  localparam logic [7:0] PFC_RST_CARRIER_WORD_HI = 8'h1e;
  localparam logic [7:0] PFC_RST_CARRIER_WORD_MID = 8'hc4;
  localparam logic [7:0] PFC_RST_CARRIER_WORD_LO = 8'hec;
  // Field positions and writable masks
  localparam int PFC_BIT_WHITE = 6;
  localparam int PFC_BIT_FMT_LO = 4;
  localparam int PFC_BIT_CRC = 2;
  localparam int PFC_BIT_LEN_LO = 0;
  localparam logic [7:0] PFC_MASK_PKTCTRL = 8'h77;
  localparam logic [7:0] PFC_MASK_IF = 8'h1f;
  localparam logic [7:0] PFC_MASK_CARRIER_WORD_HI = 8'h3f;
  // Header byte layout
  localparam int PFC_HDR_READ = 7;
  localparam int PFC_HDR_BURST = 6;
  // Frequency scaling, in units of xtal over 2^16
  localparam int PFC_IF_SHIFT = 6;
  localparam int PFC_OFF_SHIFT = 2;
  // Broadcast addresses
  localparam logic [7:0] PFC_BCAST_ZERO = 8'h00;
  localparam logic [7:0] PFC_BCAST_ONES = 8'hff;
  // PN9 seed
  localparam logic [8:0] PFC_PN9_SEED = 9'h1ff;

  typedef enum logic [1:0] {
    PFC_FMT_FIFO = 2'b00,
    PFC_FMT_SYNC = 2'b01,
    PFC_FMT_RAND = 2'b10,
    PFC_FMT_ASYNC = 2'b11
  } pfc_fmt_e;

  typedef enum logic [1:0] {
    PFC_LEN_FIXED = 2'b00,
    PFC_LEN_VAR = 2'b01,
    PFC_LEN_INF = 2'b10,
    PFC_LEN_RSVD = 2'b11
  } pfc_len_e;

  typedef enum logic [1:0] {
    PFC_SPI_HDR = 2'b00,
    PFC_SPI_DATA = 2'b01
  } pfc_spi_e;
endpackage

/* src/pfc_top.sv */
// Packet and frequency configuration bank behind the SPI port
`timescale 1ns/100ps
`default_nettype none
module pfc_top
  import pfc_pkg::*;
#(
  parameter int SPACING_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // SPI pins
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Configurable digital pin zero
  input wire logic config_pin_zero_in,
  output logic config_pin_zero_out,
  output logic config_pin_zero_oe,
  // Settings from neighbouring registers
  input wire logic [7:0] packet_length_register,
  input wire logic [1:0] address_filter_mode,
  input wire logic [SPACING_W-1:0] channel_spacing,
  // Transmit bit path
  input wire logic tx_start,
  input wire logic tx_bit_strobe,
  input wire logic tx_fifo_bit,
  output logic tx_bit_out,
  // Receive bit path
  input wire logic rx_start,
  input wire logic rx_bit_strobe,
  input wire logic rx_line_bit,
  output logic rx_fifo_bit,
  // Packet handling
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr_byte,
  input wire logic rx_len_valid,
  input wire logic [7:0] rx_len_byte,
  output logic addr_accept,
  output logic addr_reject,
  output logic len_too_long,
  output logic [7:0] packet_len_limit,
  output logic len_unbounded,
  output logic crc_enable,
  output logic use_fifo,
  // Synthesizer words, units of xtal over 2^16; IF word in xtal over 2^10, offset in xtal over 2^14
  output logic [23:0] carrier_word,
  output logic [4:0] intermediate_carrier_word_word,
  output logic [7:0] signed_carrier_word_offset,
  output logic [27:0] tx_synth_word,
  output logic [27:0] rx_synth_word
);

  // Registers
  logic [7:0] pktctrl_r, filt_addr_r, channel_index_r, if_r;
  logic [7:0] offset_r, carrier_word_hi_r, carrier_word_mid_r, carrier_word_lo_r;

  // Field views
  logic whitening_enable;
  pfc_fmt_e packet_format_select;
  pfc_len_e length_mode;
  logic [7:0] channel_index;

  assign whitening_enable = pktctrl_r[PFC_BIT_WHITE];
  assign packet_format_select = pfc_fmt_e'(pktctrl_r[PFC_BIT_FMT_LO +: 2]);
  assign length_mode = pfc_len_e'(pktctrl_r[PFC_BIT_LEN_LO +: 2]);
  assign channel_index = channel_index_r;

  // Pin synchronisers, two flops each before any use
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic sclk_d_r;
  logic sclk_s, csn_s, mosi_s, pin0_s;

  // Select parks high in reset so no frame starts early
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= 4'b0010;
      sync2_r <= 4'b0010;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r <= {config_pin_zero_in, spi_mosi, spi_csn, spi_sclk};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[0];
    end
  end

  assign sclk_s = sync2_r[0];
  assign csn_s = sync2_r[1];
  assign mosi_s = sync2_r[2];
  assign pin0_s = sync2_r[3];

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s & ~sclk_d_r & ~csn_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~csn_s;

  // Read decode, also used to load the shift register for bursts
  function automatic logic [7:0] rd_reg(input logic [5:0] a,
      input logic [7:0] p, input logic [7:0] ad, input logic [7:0] ch,
      input logic [7:0] fi, input logic [7:0] fo, input logic [7:0] fh,
      input logic [7:0] fm, input logic [7:0] fl);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      PFC_OFS_PKTCTRL: v = p & PFC_MASK_PKTCTRL;
      PFC_OFS_ADDR: v = ad;
      PFC_OFS_CHANNEL_INDEX: v = ch;
      PFC_OFS_IF: v = fi & PFC_MASK_IF;
      PFC_OFS_OFFSET: v = fo;
      PFC_OFS_CARRIER_WORD_HI: v = fh & PFC_MASK_CARRIER_WORD_HI;
      PFC_OFS_CARRIER_WORD_MID: v = fm;
      PFC_OFS_CARRIER_WORD_LO: v = fl;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // SPI framing: header byte, then data bytes, burst steps the address
  pfc_spi_e spi_state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_in_r, shift_out_r;
  logic [5:0] addr_r;
  logic rd_r, burst_r, byte_done;
  logic [7:0] byte_in;
  logic wr_stb;
  logic [7:0] rd_data;
  logic [5:0] next_addr;

  assign byte_in = {shift_in_r[6:0], mosi_s};
  assign byte_done = sclk_rise && (bit_cnt_r == 3'd7);
  assign wr_stb = byte_done && (spi_state_r == PFC_SPI_DATA) && !rd_r;
  assign next_addr = (spi_state_r == PFC_SPI_HDR) ? byte_in[5:0] :
      (burst_r ? addr_r + 6'd1 : addr_r);
  assign rd_data = rd_reg(next_addr, pktctrl_r, filt_addr_r, channel_index_r,
      if_r, offset_r, carrier_word_hi_r, carrier_word_mid_r, carrier_word_lo_r);

  // Frame tracking; a raised chip select always restarts at the header
  always_ff @(posedge clk) begin
    if (!rst_n || csn_s) begin
      spi_state_r <= PFC_SPI_HDR;
      bit_cnt_r <= 3'd0;
      shift_in_r <= 8'h00;
      addr_r <= 6'h00;
      rd_r <= 1'b0;
      burst_r <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'd1;
      shift_in_r <= byte_in;
      if (byte_done) begin
        if (spi_state_r == PFC_SPI_HDR) begin
          rd_r <= byte_in[PFC_HDR_READ];
          burst_r <= byte_in[PFC_HDR_BURST];
          addr_r <= byte_in[5:0];
          spi_state_r <= PFC_SPI_DATA;
        end else if (burst_r) begin
          addr_r <= next_addr;
        end
      end
    end
  end

  // Output shift on falling edges; read data loaded at byte boundary
  always_ff @(posedge clk) begin
    if (!rst_n || csn_s) begin
      shift_out_r <= 8'h00;
    end else if (byte_done) begin
      shift_out_r <= rd_data;
    end else if (sclk_fall && bit_cnt_r != 3'd0) begin
      shift_out_r <= {shift_out_r[6:0], 1'b0};
    end
  end

  // Pin only driven while selected, so several slaves can share it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso <= shift_out_r[7];
      spi_miso_oe <= ~csn_s;
    end
  end

  // Register writes; read-only bits are masked off on the way in
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pktctrl_r <= PFC_RST_PKTCTRL;
      filt_addr_r <= PFC_RST_ADDR;
      channel_index_r <= PFC_RST_CHANNEL_INDEX;
      if_r <= PFC_RST_IF;
      offset_r <= PFC_RST_OFFSET;
      carrier_word_hi_r <= PFC_RST_CARRIER_WORD_HI;
      carrier_word_mid_r <= PFC_RST_CARRIER_WORD_MID;
      carrier_word_lo_r <= PFC_RST_CARRIER_WORD_LO;
    end else if (wr_stb) begin
      unique case (addr_r) // Burst steps only after the write
        PFC_OFS_PKTCTRL: pktctrl_r <= byte_in & PFC_MASK_PKTCTRL;
        PFC_OFS_ADDR: filt_addr_r <= byte_in;
        PFC_OFS_CHANNEL_INDEX: channel_index_r <= byte_in;
        PFC_OFS_IF: if_r <= byte_in & PFC_MASK_IF;
        PFC_OFS_OFFSET: offset_r <= byte_in;
        PFC_OFS_CARRIER_WORD_HI: carrier_word_hi_r <= byte_in & PFC_MASK_CARRIER_WORD_HI;
        PFC_OFS_CARRIER_WORD_MID: carrier_word_mid_r <= byte_in;
        PFC_OFS_CARRIER_WORD_LO: carrier_word_lo_r <= byte_in;
        default: ;
      endcase
    end
  end

  // Frequency words; sign extension keeps negative offsets honest
  logic [23:0] carrier_nxt;
  logic [27:0] channel_index_term, off_term, if_term, base_sum;
  logic [SPACING_W+7:0] channel_index_prod;

  assign carrier_nxt = {carrier_word_hi_r, carrier_word_mid_r, carrier_word_lo_r};
  assign channel_index_prod = channel_index * channel_spacing;
  assign channel_index_term = 28'(channel_index_prod);
  assign off_term = 28'({{20{offset_r[7]}}, offset_r} <<
      PFC_OFF_SHIFT);
  assign if_term = 28'({23'h00_0000, if_r[4:0]} << PFC_IF_SHIFT);
  assign base_sum = {4'h0, carrier_nxt} + channel_index_term + off_term;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carrier_word <= 24'h00_0000;
      intermediate_carrier_word_word <= 5'h00;
      signed_carrier_word_offset <= 8'h00;
      tx_synth_word <= 28'h000_0000;
      rx_synth_word <= 28'h000_0000;
    end else begin
      carrier_word <= carrier_nxt;
      intermediate_carrier_word_word <= if_r[4:0];
      signed_carrier_word_offset <= offset_r;
      tx_synth_word <= base_sum;
      rx_synth_word <= base_sum - if_term;
    end
  end

  // PN9 step, x^9 + x^5 + 1, shared by whitening and the test source
  function automatic logic [8:0] pn9_step(input logic [8:0] s);
    return {s[0] ^ s[5], s[8:1]};
  endfunction

  logic [8:0] tx_pn9_r;
  logic [8:0] rx_pn9_r;

  // Sequences restart per packet so both ends stay aligned
  always_ff @(posedge clk) begin
    if (!rst_n || tx_start) begin
      tx_pn9_r <= PFC_PN9_SEED;
    end else if (tx_bit_strobe) begin
      tx_pn9_r <= pn9_step(tx_pn9_r);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || rx_start) begin
      rx_pn9_r <= PFC_PN9_SEED;
    end else if (rx_bit_strobe) begin
      rx_pn9_r <= pn9_step(rx_pn9_r);
    end
  end

  // Transmit source by format
  logic tx_src;
  always_comb begin
    unique case (packet_format_select)
      PFC_FMT_FIFO: tx_src = tx_fifo_bit ^
          (whitening_enable & tx_pn9_r[0]);
      PFC_FMT_SYNC: tx_src = pin0_s;
      PFC_FMT_RAND: tx_src = tx_pn9_r[0];
      PFC_FMT_ASYNC: tx_src = pin0_s;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_bit_out <= 1'b0;
    end else if (tx_bit_strobe) begin
      tx_bit_out <= tx_src;
    end
  end

  // Receive: random test format receives as the FIFO format does
  logic rx_fifo_path;
  assign rx_fifo_path = (packet_format_select == PFC_FMT_FIFO) ||
      (packet_format_select == PFC_FMT_RAND);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_fifo_bit <= 1'b0;
    end else if (rx_bit_strobe && rx_fifo_path) begin
      rx_fifo_bit <= rx_line_bit ^ (whitening_enable & rx_pn9_r[0]);
    end
  end

  // Pin zero carries raw received data only in asynchronous format
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_pin_zero_out <= 1'b0;
      config_pin_zero_oe <= 1'b0;
    end else begin
      config_pin_zero_out <= rx_line_bit;
      config_pin_zero_oe <= (packet_format_select == PFC_FMT_ASYNC);
    end
  end

  // Address filter, one verdict pulse per address byte
  logic addr_ok;
  always_comb begin
    unique case (address_filter_mode)
      2'b00: addr_ok = 1'b1;
      2'b01: addr_ok = (rx_addr_byte == filt_addr_r);
      2'b10: addr_ok = (rx_addr_byte == filt_addr_r) ||
          (rx_addr_byte == PFC_BCAST_ZERO);
      2'b11: addr_ok = (rx_addr_byte == filt_addr_r) ||
          (rx_addr_byte == PFC_BCAST_ZERO) ||
          (rx_addr_byte == PFC_BCAST_ONES);
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_accept <= 1'b0;
      addr_reject <= 1'b0;
    end else begin
      addr_accept <= rx_addr_valid & addr_ok;
      addr_reject <= rx_addr_valid & ~addr_ok;
    end
  end

  // Length handling; the reserved code falls back to fixed length
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      packet_len_limit <= 8'h00;
      len_unbounded <= 1'b0;
      len_too_long <= 1'b0;
    end else begin
      len_unbounded <= (length_mode == PFC_LEN_INF);
      len_too_long <= 1'b0;
      unique case (length_mode)
        PFC_LEN_VAR: begin
          if (rx_len_valid) begin
            packet_len_limit <= rx_len_byte;
            len_too_long <= rx_len_byte > packet_length_register;
          end
        end
        PFC_LEN_INF: packet_len_limit <= packet_length_register;
        PFC_LEN_FIXED, PFC_LEN_RSVD: begin
          packet_len_limit <= packet_length_register;
        end
      endcase
    end
  end

  // Static mode flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_enable <= 1'b0;
      use_fifo <= 1'b0;
    end else begin
      crc_enable <= pktctrl_r[PFC_BIT_CRC];
      use_fifo <= rx_fifo_path;
    end
  end

endmodule
`default_nettype wire

/* tb/pfc_asserts.sv */
// Port-level checks for the packet and frequency configuration bank
`timescale 1ns/100ps
`default_nettype none
module pfc_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs that cause the checked outputs
  input wire logic rx_line_bit,
  input wire logic tx_bit_strobe,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr_byte,
  input wire logic [1:0] address_filter_mode,
  input wire logic rx_len_valid,
  input wire logic [7:0] rx_len_byte,
  input wire logic [7:0] packet_length_register,
  // Outputs under watch
  input wire logic addr_accept,
  input wire logic addr_reject,
  input wire logic len_too_long,
  input wire logic use_fifo,
  input wire logic tx_bit_out,
  input wire logic config_pin_zero_out,
  input wire logic config_pin_zero_oe,
  input wire logic [23:0] carrier_word,
  input wire logic [4:0] intermediate_carrier_word_word,
  input wire logic [27:0] tx_synth_word,
  input wire logic [27:0] rx_synth_word
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Address verdicts: exactly one, a cycle after the strobe
  property p_addr_once;
    rx_addr_valid |=> addr_accept ^ addr_reject;
  endproperty
  a_addr_once: assert property (p_addr_once)
    else $error("address strobe without a single verdict");
  property p_no_check;
    rx_addr_valid && address_filter_mode == 2'h0 |=> addr_accept;
  endproperty
  a_no_check: assert property (p_no_check)
    else $error("address refused with filtering off");
  property p_bcast_zero;
    rx_addr_valid && address_filter_mode[1] && rx_addr_byte == 8'h00
      |=> addr_accept;
  endproperty
  a_bcast_zero: assert property (p_bcast_zero)
    else $error("zero broadcast refused");
  property p_bcast_ones;
    rx_addr_valid && address_filter_mode == 2'h3 && rx_addr_byte == 8'hff
      |=> addr_accept;
  endproperty
  a_bcast_ones: assert property (p_bcast_ones)
    else $error("all-ones broadcast refused");
  // Length flag only for a byte above the limit
  property p_len_long;
    len_too_long |-> $past(rx_len_valid)
      && $past(rx_len_byte) > $past(packet_length_register);
  endproperty
  a_len_long: assert property (p_len_long)
    else $error("length flag without an oversize length byte");
  // Serial modes bypass the FIFOs
  property p_oe_nofifo;
    config_pin_zero_oe |-> !use_fifo;
  endproperty
  a_oe_nofifo: assert property (p_oe_nofifo)
    else $error("pin driven while FIFO path in use");
  property p_pin_copy;
    $past(rst_n) |-> config_pin_zero_out == $past(rx_line_bit);
  endproperty
  a_pin_copy: assert property (p_pin_copy)
    else $error("received bit not presented on pin");
  property p_top_zero;
    carrier_word[23:22] == 2'h0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("carrier word top bits not zero");
  // Settled words only; a write in flight may skew one cycle
  property p_rx_word;
    $past(rst_n) && $stable(tx_synth_word)
      && $stable(intermediate_carrier_word_word) |-> rx_synth_word ==
      tx_synth_word - {17'h0_0000, intermediate_carrier_word_word, 6'h00};
  endproperty
  a_rx_word: assert property (p_rx_word)
    else $error("receive word not transmit word less IF");
  property p_tx_hold;
    $past(rst_n) && !$past(tx_bit_strobe) |-> $stable(tx_bit_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit bit moved without a strobe");
  // Main scenarios reached
  c_reject: cover property (addr_reject);
  c_long: cover property (len_too_long);
  c_async: cover property (config_pin_zero_oe);
endmodule
bind pfc_top pfc_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .rx_line_bit(rx_line_bit),
  .tx_bit_strobe(tx_bit_strobe), .rx_addr_valid(rx_addr_valid),
  .rx_addr_byte(rx_addr_byte), .address_filter_mode(address_filter_mode),
  .rx_len_valid(rx_len_valid), .rx_len_byte(rx_len_byte),
  .packet_length_register(packet_length_register),
  .addr_accept(addr_accept), .addr_reject(addr_reject),
  .len_too_long(len_too_long), .use_fifo(use_fifo),
  .tx_bit_out(tx_bit_out), .config_pin_zero_out(config_pin_zero_out),
  .config_pin_zero_oe(config_pin_zero_oe), .carrier_word(carrier_word),
  .intermediate_carrier_word_word(intermediate_carrier_word_word),
  .tx_synth_word(tx_synth_word), .rx_synth_word(rx_synth_word)
);
`default_nettype wire

/* tb/pfc_host.sv */
// Host microcontroller model driving the SPI pins
`timescale 1ns/100ps
`default_nettype none
module pfc_host (
  // Clock
  input wire logic clk,
  // SPI pins
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Half period in clocks; the bank needs at least five
  localparam int HALF = 6;
  // Idle pins: clock parked low, select off
  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
  end
  // One byte, MSB first; data set while clock low, read at its rise
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      spi_sclk <= 1'b0;
      spi_mosi <= d[i];
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b1;
      q[i] = spi_miso;
      repeat (HALF - 1) @(posedge clk);
    end
  endtask
  // Header plus one data byte, or two after a burst header, select framing them
  task automatic frame(input logic [7:0] h, input logic [7:0] d,
      output logic [7:0] q);
    logic [7:0] s;
    @(posedge clk);
    spi_csn <= 1'b0;
    repeat (HALF) @(posedge clk);
    xbyte(h, s);
    xbyte(d, q);
    if (h[6]) xbyte(d + 8'h01, s); // Burst header adds a second byte
    @(posedge clk);
    spi_sclk <= 1'b0;
    repeat (HALF) @(posedge clk);
    spi_csn <= 1'b1;
    spi_mosi <= ~spi_mosi; // Released line must not echo old data
    repeat (2 * HALF) @(posedge clk);
  endtask
  // Single write; reserved length code is never sent
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    if (a == 6'h08 && d[1:0] == 2'h3) return;
    frame({2'h0, a}, d, q);
  endtask
  // Single read
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    frame({2'h2, a}, 8'h00, q);
  endtask
  // Burst write: d at address a, d plus one at the next address
  task automatic wrb(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame({2'h1, a}, d, q);
  endtask
endmodule
`default_nettype wire

/* tb/test_packet_and_frequency_config.sv */
// Self-checking bench for the packet and frequency configuration bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_packet_and_frequency_config;
  import pfc_pkg::*;
  // Counters, clock and stimulus
  int n_mismatch = 0;
  int checked = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, csn, mosi, miso, miso_oe, pz_out, pz_oe, tx_out, rx_fifo;
  logic pz_in = 1'b0;
  logic [7:0] plr = 8'h20;
  logic [1:0] afm = 2'h0;
  logic [15:0] spc = 16'h0100;
  logic tx_start = 1'b0, tx_stb = 1'b0, tx_fifo = 1'b0;
  logic rx_start = 1'b0, rx_stb = 1'b0, rx_line = 1'b0;
  logic av = 1'b0, lv = 1'b0;
  logic [7:0] ab = 8'h00, lb = 8'h00;
  logic acc, rej, len_long, len_unb, crc_en, use_fifo;
  logic [7:0] len_lim, off;
  logic [23:0] cw;
  logic [4:0] ifw;
  logic [27:0] txw, rxw;
  logic [7:0] rv [8] = '{8'h45, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4,
    8'hec};
  logic [7:0] mk [8] = '{8'h76, 8'hfe, 8'hfe, 8'h1e, 8'hfe, 8'h3e, 8'hfe,
    8'hfe};
  logic [7:0] abyte [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};
  // Design and host
  pfc_top #(.SPACING_W(16)) uut (
    .clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_csn(csn),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .config_pin_zero_in(pz_in), .config_pin_zero_out(pz_out),
    .config_pin_zero_oe(pz_oe), .packet_length_register(plr),
    .address_filter_mode(afm), .channel_spacing(spc),
    .tx_start(tx_start), .tx_bit_strobe(tx_stb), .tx_fifo_bit(tx_fifo),
    .tx_bit_out(tx_out), .rx_start(rx_start), .rx_bit_strobe(rx_stb),
    .rx_line_bit(rx_line), .rx_fifo_bit(rx_fifo), .rx_addr_valid(av),
    .rx_addr_byte(ab), .rx_len_valid(lv), .rx_len_byte(lb),
    .addr_accept(acc), .addr_reject(rej), .len_too_long(len_long),
    .packet_len_limit(len_lim), .len_unbounded(len_unb),
    .crc_enable(crc_en), .use_fifo(use_fifo), .carrier_word(cw),
    .intermediate_carrier_word_word(ifw), .signed_carrier_word_offset(off),
    .tx_synth_word(txw), .rx_synth_word(rxw)
  );
  pfc_host host (.clk(clk), .spi_sclk(sclk), .spi_csn(csn),
    .spi_mosi(mosi), .spi_miso(miso));
  // Clock
  initial begin
    forever #50 clk = ~clk;
  end
  // Verdict, reached from the main flow or the watchdog
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Register read and compare
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.rd(a, q);
    `CHK(q, e)
  endtask
  // One bit time on both paths; outputs land the edge after the strobe
  task automatic step(input logic f, input logic l, output logic t,
      output logic r);
    @(posedge clk);
    tx_fifo <= f;
    rx_line <= l;
    tx_stb <= 1'b1;
    rx_stb <= 1'b1;
    @(posedge clk);
    tx_stb <= 1'b0;
    rx_stb <= 1'b0;
    @(negedge clk);
    t = tx_out;
    r = rx_fifo;
  endtask
  // Reseed both generators, then sixteen zero bits
  task automatic seq(output logic [15:0] ts, output logic [15:0] rs);
    @(posedge clk);
    tx_start <= 1'b1;
    rx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    rx_start <= 1'b0;
    for (int i = 0; i < 16; i++) step(1'b0, 1'b0, ts[i], rs[i]);
  endtask
  // Address or length byte strobe, verdict sampled a cycle later
  task automatic ev(input logic is_addr, input logic [7:0] b);
    @(posedge clk);
    av <= is_addr;
    lv <= !is_addr;
    ab <= b;
    lb <= b;
    @(posedge clk);
    av <= 1'b0;
    lv <= 1'b0;
    @(negedge clk);
  endtask
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  // Main sequence
  initial begin
    logic e, t, r;
    logic [15:0] t1, r1, t2, r2;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++) rchk(6'h08 + 6'(i), rv[i]);
    `CHK(cw, 24'h1e_c4ec)
    `CHK(ifw, 5'h0f)
    `CHK(miso_oe, 1'b0)
    // All-ones-but-one pattern, masked by read-only bits
    for (int i = 0; i < 8; i++) host.wr(6'h08 + 6'(i), 8'hfe);
    host.wr(6'h10, 8'hff);
    rchk(6'h10, 8'h00);
    for (int i = 0; i < 8; i++) rchk(6'h08 + 6'(i), mk[i]);
    `CHK(cw, 24'h3e_fefe)
    // Channel 0xfe at spacing 0x100; offset -2 is four units a step
    `CHK(txw, 28'h03e_fefe + 28'h000_fe00 - 28'h000_0008)
    `CHK(rxw, 28'h03e_fefe + 28'h000_fe00 - 28'h000_0788)
    `CHK(ifw, 5'h1e)
    `CHK(off, 8'hfe)
    // Every format and legal length code
    for (int f = 0; f < 4; f++) begin
      for (int l = 0; l < 3; l++) begin
        host.wr(6'h08, {2'h0, 2'(f), 1'b0, 1'(f), 2'(l)});
        `CHK(use_fifo, 1'(f == 0 || f == 2))
        `CHK(pz_oe, 1'(f == 3))
        `CHK(crc_en, 1'(f))
        `CHK(len_unb, 1'(l == 2))
        if (l < 2) `CHK(len_lim, plr)
      end
    end
    host.wr(6'h08, 8'h01);
    ev(1'b0, 8'h21);
    `CHK(len_long, 1'b1)
    ev(1'b0, 8'h20);
    `CHK(len_long, 1'b0)
    // FIFO path plain and whitened, then the random test format
    host.wr(6'h08, 8'h00);
    for (int i = 0; i < 4; i++) begin
      step(1'(i), 1'(i >> 1), t, r);
      `CHK(t, 1'(i))
      `CHK(r, 1'(i >> 1))
    end
    host.wr(6'h08, 8'h40);
    seq(t1, r1);
    host.wr(6'h08, 8'h20);
    seq(t2, r2);
    `CHK(t1[4:0], 5'h1f)
    `CHK(t1 == 16'hffff, 1'b0)
    `CHK(r1, t1)
    `CHK(t2, t1)
    `CHK(r2, 16'h0000)
    // Serial formats take transmit data from pin zero
    for (int k = 0; k < 2; k++) begin
      host.wr(6'h08, k ? 8'h30 : 8'h10);
      for (int i = 1; i >= 0; i--) begin
        @(posedge clk);
        pz_in <= 1'(i);
        repeat (3) @(posedge clk);
        step(1'(~i), 1'(i), t, r);
        `CHK(t, 1'(i))
        `CHK(pz_out, 1'(i))
      end
    end
    // Address filter, every mode against a table of bytes
    host.wr(6'h09, 8'h5a);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      afm <= 2'(m);
      for (int j = 0; j < 4; j++) begin
        e = (m == 0 || j == 0 || (m > 1 && j == 1) || (m == 3 && j == 2));
        ev(1'b1, abyte[j]);
        `CHK(acc, e)
        `CHK(rej, !e)
      end
    end
    // Burst write lands on two neighbouring bytes
    host.wrb(6'h0e, 8'h12);
    rchk(6'h0e, 8'h12);
    rchk(6'h0f, 8'h13);
    `CHK(cw, 24'h3e_1213)
    final_report();
  end
endmodule
`default_nettype wire
